// File: hdl/ebct_pkg.sv
// constants and types for the eight-bit compare timer
package ebct_pkg;
    // ****************************************
    // clock select codes {clock_select}
    // ****************************************
    localparam logic [2:0] EBCT_CKS_STOP0  = 3'h0;
    localparam logic [2:0] EBCT_CKS_INT_A  = 3'h1; // extra=0: /4, extra=1: /8
    localparam logic [2:0] EBCT_CKS_INT_B  = 3'h2; // extra=0: /16, extra=1: /32
    localparam logic [2:0] EBCT_CKS_INT_C  = 3'h3; // extra=0: /64, extra=1: /128
    localparam logic [2:0] EBCT_CKS_STOP4  = 3'h4;
    localparam logic [2:0] EBCT_CKS_EXT_RISE = 3'h5;
    localparam logic [2:0] EBCT_CKS_EXT_FALL = 3'h6;
    localparam logic [2:0] EBCT_CKS_EXT_BOTH = 3'h7;
    localparam int         EBCT_PRE_W      = 7;
    // ****************************************
    // clear select codes
    // ****************************************
    localparam logic [1:0] EBCT_CLR_NONE   = 2'h0;
    localparam logic [1:0] EBCT_CLR_MATCHA = 2'h1;
    localparam logic [1:0] EBCT_CLR_MATCHB = 2'h2;
    localparam logic [1:0] EBCT_CLR_EXT    = 2'h3;
    // ****************************************
    // trigger edge select codes
    // ****************************************
    localparam logic [1:0] EBCT_TRG_NONE   = 2'h0;
    localparam logic [1:0] EBCT_TRG_RISE   = 2'h1;
    localparam logic [1:0] EBCT_TRG_FALL   = 2'h2;
    localparam logic [1:0] EBCT_TRG_BOTH   = 2'h3;
    // ****************************************
    // output action codes (two bits per match)
    // ****************************************
    localparam logic [1:0] EBCT_OUT_KEEP   = 2'h0;
    localparam logic [1:0] EBCT_OUT_LOW    = 2'h1;
    localparam logic [1:0] EBCT_OUT_HIGH   = 2'h2;
    localparam logic [1:0] EBCT_OUT_TOGGLE = 2'h3;
    // ****************************************
    // reset values and widths
    // ****************************************
    localparam logic [7:0] EBCT_CNT_MAX    = 8'hff;
    localparam logic [7:0] EBCT_CNT_RST    = 8'h00;
    localparam logic [7:0] EBCT_CONST_RST  = 8'hff;
    // timer run state, gray coded
    typedef enum logic [0:0] {
        EBCT_RUN  = 1'b0,
        EBCT_HALT = 1'b1
    } ebct_state_t;
endpackage : ebct_pkg

// File: hdl/ebct_timer.sv
// eight-bit up counter with two compare constants, clear and trigger gating
module ebct_timer
    import ebct_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire logic       nrst_in,
    input  wire logic [2:0] clock_select_in,
    input  wire logic       clock_select_extra_in,
    input  wire logic [1:0] clear_select_in,
    input  wire logic       trigger_gate_enable_in,
    input  wire logic [1:0] trigger_edge_select_in,
    input  wire logic [3:0] output_select_in,
    input  wire logic [7:0] compare_const_a_in,
    input  wire logic [7:0] compare_const_b_in,
    input  wire logic       wrap_irq_enable_in,
    input  wire logic       match_irq_enable_a_in,
    input  wire logic       match_irq_enable_b_in,
    input  wire logic       wrap_flag_clr_in,
    input  wire logic       match_flag_a_clr_in,
    input  wire logic       match_flag_b_clr_in,
    input  wire logic       count_load_in,
    input  wire logic [7:0] count_load_value_in,
    input  wire logic       ext_clock_in,
    input  wire logic       external_clear_input_in,
    input  wire logic       trigger_input_pin_in,
    output logic      [7:0] count_value_out,
    output logic            wrap_flag_out,
    output logic            match_flag_a_out,
    output logic            match_flag_b_out,
    output logic            wrap_irq_out,
    output logic            match_irq_a_out,
    output logic            match_irq_b_out,
    output logic            waveform_output_pin_out,
    output logic            halted_out
);
    // ****************************************
    // state
    // ****************************************
    logic [EBCT_PRE_W-1:0] pre_reg,   pre_next;
    logic [7:0]            cnt_reg,   cnt_next;
    logic                  ovf_reg,   ovf_next;
    logic                  mfa_reg,   mfa_next;
    logic                  mfb_reg,   mfb_next;
    logic                  wave_reg,  wave_next;
    logic                  ext_d_reg, clr_d_reg, trg_d_reg;
    ebct_state_t           st_reg,    st_next;
    logic                  tick;
    logic                  ext_rise, ext_fall, clr_rise, trg_rise, trg_fall;
    logic                  eq_a, eq_b, match_a, match_b, clr_evt, trg_evt;

    // ****************************************
    // edge detection (pins are synchronous)
    // ****************************************
    assign ext_rise = ext_clock_in & ~ext_d_reg;
    assign ext_fall = ~ext_clock_in & ext_d_reg;
    // the source must hold clear high over a sampling edge, hence its 1.5 clock minimum
    assign clr_rise = external_clear_input_in & ~clr_d_reg;
    assign trg_rise = trigger_input_pin_in & ~trg_d_reg;
    assign trg_fall = ~trigger_input_pin_in & trg_d_reg;

    // ****************************************
    // clock source selection
    // ****************************************
    // prescaler taps picked by the three-bit field and the extra bit together
    always_comb begin
        tick = 1'b0;
        case (clock_select_in)
            EBCT_CKS_INT_A:    tick = clock_select_extra_in ? (pre_reg[2:0] == 3'h7)
                                                             : (pre_reg[1:0] == 2'h3);
            EBCT_CKS_INT_B:    tick = clock_select_extra_in ? (pre_reg[4:0] == 5'h1f)
                                                             : (pre_reg[3:0] == 4'hf);
            EBCT_CKS_INT_C:    tick = clock_select_extra_in ? (pre_reg == 7'h7f)
                                                             : (pre_reg[5:0] == 6'h3f);
            EBCT_CKS_EXT_RISE: tick = ext_rise;
            EBCT_CKS_EXT_FALL: tick = ext_fall;
            EBCT_CKS_EXT_BOTH: tick = ext_rise | ext_fall;
            default:           tick = 1'b0;
        endcase
    end

    // ****************************************
    // compare and clear sources
    // ****************************************
    // the match fires on the last clock of the equal period, i.e. when the count is about to move
    assign eq_a    = (cnt_reg == compare_const_a_in);
    assign eq_b    = (cnt_reg == compare_const_b_in);
    assign match_a = eq_a & tick & (st_reg == EBCT_RUN);
    assign match_b = eq_b & tick & (st_reg == EBCT_RUN);
    always_comb begin
        case (clear_select_in)
            EBCT_CLR_MATCHA: clr_evt = match_a;
            EBCT_CLR_MATCHB: clr_evt = match_b;
            EBCT_CLR_EXT:    clr_evt = clr_rise;
            default:         clr_evt = 1'b0;
        endcase
    end
    always_comb begin
        case (trigger_edge_select_in)
            EBCT_TRG_RISE: trg_evt = trg_rise;
            EBCT_TRG_FALL: trg_evt = trg_fall;
            EBCT_TRG_BOTH: trg_evt = trg_rise | trg_fall;
            default:       trg_evt = 1'b0;
        endcase
    end

    // ****************************************
    // next-state logic
    // ****************************************
    // flags: hardware set wins over a software clear in the same cycle
    always_comb begin
        pre_next  = pre_reg + 7'h01;
        cnt_next  = cnt_reg;
        st_next   = st_reg;
        wave_next = wave_reg;
        case (st_reg)
            EBCT_RUN: begin
                if (clr_evt) begin
                    cnt_next = EBCT_CNT_RST;
                    if (trigger_gate_enable_in)
                        st_next = EBCT_HALT;
                end else if (tick) begin
                    cnt_next = cnt_reg + 8'h01;
                end
            end
            EBCT_HALT: begin
                if (clr_evt)
                    cnt_next = EBCT_CNT_RST;
                if (trg_evt || !trigger_gate_enable_in)
                    st_next = EBCT_RUN;
            end
            default: st_next = EBCT_RUN;
        endcase
        if (count_load_in)
            cnt_next = count_load_value_in;
        // match b applied first so that match a takes priority on a tie
        if (match_b) begin
            case (output_select_in[3:2])
                EBCT_OUT_LOW:    wave_next = 1'b0;
                EBCT_OUT_HIGH:   wave_next = 1'b1;
                EBCT_OUT_TOGGLE: wave_next = ~wave_next;
                default:         wave_next = wave_next;
            endcase
        end
        // a toggles from the held level, so a same-cycle b action cannot cancel it
        if (match_a) begin
            case (output_select_in[1:0])
                EBCT_OUT_LOW:    wave_next = 1'b0;
                EBCT_OUT_HIGH:   wave_next = 1'b1;
                EBCT_OUT_TOGGLE: wave_next = ~wave_reg;
                default:         wave_next = wave_next;
            endcase
        end
        ovf_next = (tick && !clr_evt && st_reg == EBCT_RUN && cnt_reg == EBCT_CNT_MAX)
                   | (ovf_reg & ~wrap_flag_clr_in);
        mfa_next = match_a | (mfa_reg & ~match_flag_a_clr_in);
        mfb_next = match_b | (mfb_reg & ~match_flag_b_clr_in);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pre_reg   <= '0;
            cnt_reg   <= EBCT_CNT_RST;
            ovf_reg   <= 1'b0;
            mfa_reg   <= 1'b0;
            mfb_reg   <= 1'b0;
            wave_reg  <= 1'b0;
            ext_d_reg <= 1'b0;
            clr_d_reg <= 1'b0;
            trg_d_reg <= 1'b0;
            st_reg    <= EBCT_RUN;
        end else begin
            pre_reg   <= pre_next;
            cnt_reg   <= cnt_next;
            ovf_reg   <= ovf_next;
            mfa_reg   <= mfa_next;
            mfb_reg   <= mfb_next;
            wave_reg  <= wave_next;
            ext_d_reg <= ext_clock_in;
            clr_d_reg <= external_clear_input_in;
            trg_d_reg <= trigger_input_pin_in;
            st_reg    <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign count_value_out         = cnt_reg;
    assign wrap_flag_out           = ovf_reg;
    assign match_flag_a_out        = mfa_reg;
    assign match_flag_b_out        = mfb_reg;
    assign wrap_irq_out            = ovf_reg & wrap_irq_enable_in;
    assign match_irq_a_out         = mfa_reg & match_irq_enable_a_in;
    assign match_irq_b_out         = mfb_reg & match_irq_enable_b_in;
    assign waveform_output_pin_out = wave_reg;
    assign halted_out              = (st_reg == EBCT_HALT);

    // ****************************************
    // assertions
    // ****************************************
    sequence wrap_seq;
        tick && !clr_evt && !count_load_in && st_reg == EBCT_RUN && cnt_reg == EBCT_CNT_MAX;
    endsequence
    sequence halt_seq;
        clr_evt && trigger_gate_enable_in && st_reg == EBCT_RUN && !count_load_in;
    endsequence

    wrap_flag_set_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        wrap_seq |=> wrap_flag_out && count_value_out == EBCT_CNT_RST)
        else $error("wrap did not set flag or zero counter");
    wrap_irq_gate_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        wrap_irq_out == (wrap_flag_out && wrap_irq_enable_in))
        else $error("wrap irq not gated by enable");
    match_a_set_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (eq_a && tick && !halted_out) |=> match_flag_a_out)
        else $error("match a flag not set");
    match_last_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        ($rose(match_flag_a_out) && !$past(match_flag_a_clr_in)) |->
        $past(eq_a) && $past(tick))
        else $error("match a flag set outside last equal clock");
    match_irq_gate_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        match_irq_b_out == (match_flag_b_out && match_irq_enable_b_in))
        else $error("match b irq not gated by enable");
    wave_toggle_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (match_a && output_select_in[1:0] == EBCT_OUT_TOGGLE) |=>
        waveform_output_pin_out != $past(waveform_output_pin_out))
        else $error("waveform did not toggle on match a");
    clear_match_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (match_a && clear_select_in == EBCT_CLR_MATCHA && !count_load_in) |=>
        count_value_out == EBCT_CNT_RST)
        else $error("counter not cleared on match a");
    clear_ext_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (clr_rise && clear_select_in == EBCT_CLR_EXT && !count_load_in) |=>
        count_value_out == EBCT_CNT_RST)
        else $error("counter not cleared on clear pin edge");
    trig_halt_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        halt_seq |=> halted_out && count_value_out == EBCT_CNT_RST)
        else $error("trigger gate did not halt counter");
    trig_resume_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (halted_out && !trg_evt && trigger_gate_enable_in && !count_load_in && !clr_evt) |=>
        $stable(count_value_out) && halted_out)
        else $error("halted counter moved without trigger");
    flag_hold_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (match_flag_b_out && !match_flag_b_clr_in) |=> match_flag_b_out)
        else $error("match b flag dropped without clear");

    // ****************************************
    // b channel, quiet paths and clock taps
    // ****************************************
    // the bench reaches some of these only indirectly, so they guard the gaps
    sequence match_b_seq;
        eq_b && tick && st_reg == EBCT_RUN;
    endsequence
    sequence stop_seq;
        (clock_select_in == EBCT_CKS_STOP0 || clock_select_in == EBCT_CKS_STOP4)
        && !clr_evt && !count_load_in;
    endsequence
    sequence step_seq;
        tick && st_reg == EBCT_RUN && !clr_evt && !count_load_in;
    endsequence

    count_up_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        step_seq |=> count_value_out == $past(count_value_out) + 8'h01)
        else $error("counter did not step up on a tick");
    stop_hold_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        stop_seq |=> $stable(count_value_out))
        else $error("counter moved with a stop code");
    both_edges_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (clock_select_in == EBCT_CKS_EXT_BOTH && ext_clock_in != ext_d_reg) |-> tick)
        else $error("external edge missed in both-edge mode");
    match_b_set_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        match_b_seq |=> match_flag_b_out)
        else $error("match b flag not set");
    irq_a_gate_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        match_irq_a_out == (match_flag_a_out && match_irq_enable_a_in))
        else $error("match a irq not gated by enable");
    wave_b_toggle_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (match_b_seq ##0 (!match_a && output_select_in[3:2] == EBCT_OUT_TOGGLE)) |=>
        waveform_output_pin_out != $past(waveform_output_pin_out))
        else $error("waveform did not toggle on match b");
    clear_match_b_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (match_b_seq ##0 (clear_select_in == EBCT_CLR_MATCHB && !count_load_in)) |=>
        count_value_out == EBCT_CNT_RST)
        else $error("counter not cleared on match b");
    halt_no_match_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (halted_out && !match_flag_a_out && !match_flag_b_out) |=>
        !match_flag_a_out && !match_flag_b_out)
        else $error("match flag set while halted");
    trig_go_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (halted_out && trg_evt) |=> !halted_out)
        else $error("trigger edge did not restart counter");
    tap_slow_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (clock_select_in == EBCT_CKS_INT_C && clock_select_extra_in && pre_reg != 7'h7f) |->
        !tick)
        else $error("slowest tap ticked off its prescaler phase");
    wrap_hold_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (wrap_flag_out && !wrap_flag_clr_in) |=> wrap_flag_out)
        else $error("wrap flag dropped without clear");
    flag_a_hold_a: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
        (match_flag_a_out && !match_flag_a_clr_in) |=> match_flag_a_out)
        else $error("match a flag dropped without clear");
endmodule : ebct_timer

// File: testbench/ebct_pins_model.sv
// model of the external clock, clear and trigger pins driving the timer
module ebct_pins_model (
    input  wire logic ref_clk_in,
    output logic      ext_clock_out,
    output logic      ext_clear_out,
    output logic      trigger_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // pin drivers, all moved just after a rising edge
    // ****************************************
    // pins idle low until a task moves them
    initial begin
        ext_clock_out = 1'b0;
        ext_clear_out = 1'b0;
        trigger_out = 1'b0;
    end
    // n external clock edges, gap clocks apart so each edge is sampled
    task automatic clk_edges(input int n, input int gap);
        repeat (n) begin
            repeat (gap) @(posedge ref_clk_in);
            #2;
            ext_clock_out = ~ext_clock_out;
        end
    endtask : clk_edges
    // held two clocks, the shortest whole count above one and a half
    task automatic clear_pulse();
        @(posedge ref_clk_in);
        #2;
        ext_clear_out = 1'b1;
        repeat (2) @(posedge ref_clk_in);
        #2;
        ext_clear_out = 1'b0;
    endtask : clear_pulse
    // trigger level change on the next clock
    task automatic trig_set(input logic v);
        @(posedge ref_clk_in);
        #2;
        trigger_out = v;
    endtask : trig_set
endmodule : ebct_pins_model

// File: testbench/tb_ebct_timer.sv
// self-checking bench for the eight-bit compare timer
module tb_ebct_timer
    import ebct_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       ref_clk_in = 1'b0;
    logic       nrst_in = 1'b0;
    logic [2:0] clock_select_in = 3'h0;
    logic       clock_select_extra_in = 1'b0;
    logic [1:0] clear_select_in = 2'h0;
    logic       trigger_gate_enable_in = 1'b0;
    logic [1:0] trigger_edge_select_in = 2'h0;
    logic [3:0] output_select_in = 4'h0;
    logic [7:0] compare_const_a_in = 8'hff;
    logic [7:0] compare_const_b_in = 8'hff;
    logic       wrap_irq_enable_in = 1'b0;
    logic       match_irq_enable_a_in = 1'b0;
    logic       match_irq_enable_b_in = 1'b0;
    logic       wrap_flag_clr_in = 1'b0;
    logic       match_flag_a_clr_in = 1'b0;
    logic       match_flag_b_clr_in = 1'b0;
    logic       count_load_in = 1'b0;
    logic [7:0] count_load_value_in = 8'h00;
    wire logic  ext_clock_in, external_clear_input_in, trigger_input_pin_in;
    logic [7:0] count_value_out;
    logic       wrap_flag_out, match_flag_a_out, match_flag_b_out, wrap_irq_out;
    logic       match_irq_a_out, match_irq_b_out, waveform_output_pin_out, halted_out;
    int         n_mismatch = 0, total_checks = 0, cyc_cnt = 0;
    ebct_pins_model pins (
        .ref_clk_in    (ref_clk_in),
        .ext_clock_out (ext_clock_in),
        .ext_clear_out (external_clear_input_in),
        .trigger_out   (trigger_input_pin_in)
    );
    ebct_timer DUT (.*);
    // ****************************************
    // clock, watchdog and helpers
    // ****************************************
    always #20 ref_clk_in = ~ref_clk_in;
    // runs are a few thousand cycles, so this only trips on a hang
    always @(posedge ref_clk_in) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    // inputs always move two ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #2;
    endtask : cyc
    task automatic load(input logic [7:0] v);
        count_load_in = 1'b1;
        count_load_value_in = v;
        cyc(1);
        count_load_in = 1'b0;
    endtask : load
    // which: 0 flag a, 1 flag b, 2 counter at zero; prev is the count before
    task automatic wait_until(input int which, output logic [7:0] prev);
        for (int i = 0; i < 1000; i++) begin
            prev = count_value_out;
            cyc(1);
            if ((which == 0 && match_flag_a_out === 1'b1) ||
                (which == 1 && match_flag_b_out === 1'b1) ||
                (which == 2 && count_value_out === 8'h00)) break;
        end
    endtask : wait_until
    function automatic logic wave_exp(input logic [1:0] act, input logic w);
        case (act)
            EBCT_OUT_LOW:    return 1'b0;
            EBCT_OUT_HIGH:   return 1'b1;
            EBCT_OUT_TOGGLE: return ~w;
            default:         return w;
        endcase
    endfunction : wave_exp
    // main sequence
    initial begin
        logic [7:0] v, prev;
        logic       w, e;
        logic [1:0] act;
        void'($urandom(32'h3dafe2c2));
        cyc(8);
        nrst_in = 1'b1;
        check("rst", count_value_out, 8'h00);
        // six internal taps: exactly div clocks between ticks
        for (int i = 0; i < 6; i++) begin
            clock_select_in = 3'(1 + i / 2);
            clock_select_extra_in = i[0];
            cyc(2);
            v = count_value_out;
            for (int k = 0; k < 300 && count_value_out === v; k++) cyc(1);
            v = count_value_out;
            cyc((4 << i) - 1);
            check("early", count_value_out, v);
            cyc(1);
            check("tick", count_value_out, v + 8'h01);
        end
        for (int i = 0; i < 2; i++) begin
            clock_select_in = i ? EBCT_CKS_STOP4 : EBCT_CKS_STOP0;
            cyc(2);
            v = count_value_out;
            cyc(200);
            check("stop", count_value_out, v);
        end
        // six external edges: three rises, three falls
        for (int j = 5; j < 8; j++) begin
            clock_select_in = 3'(j);
            cyc(2);
            v = count_value_out;
            pins.clk_edges(6, 3);
            cyc(3);
            check("ext", count_value_out, v + ((j == 7) ? 8'h06 : 8'h03));
        end
        clock_select_in = EBCT_CKS_INT_A;
        clock_select_extra_in = 1'b0;
        compare_const_a_in = 8'h80;
        compare_const_b_in = 8'h80;
        for (int i = 0; i < 2; i++) begin
            wrap_irq_enable_in = i[0];
            wrap_flag_clr_in = 1'b1;
            load(8'hfd);
            wrap_flag_clr_in = 1'b0;
            wait_until(2, prev);
            check("wrap", wrap_flag_out, 1'b1);
            check("wirq", wrap_irq_out, wrap_irq_enable_in);
            cyc(20);
            check("hold", wrap_flag_out, 1'b1);
            wrap_flag_clr_in = 1'b1;
            cyc(1);
            wrap_flag_clr_in = 1'b0;
            check("wclr", wrap_flag_out, 1'b0);
        end
        // every output action on each match, counter cleared by that match
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 4; k++) begin
                // zero the count first, so a new constant never meets a stale count
                match_flag_a_clr_in = 1'b1;
                match_flag_b_clr_in = 1'b1;
                load(8'h00);
                match_flag_a_clr_in = 1'b0;
                match_flag_b_clr_in = 1'b0;
                // actions run high, keep, low, toggle so each one moves or holds a level
                act = 2'(8'hd2 >> (2 * k));
                v = 8'(2 + $urandom % 100);
                e = 1'($urandom);
                compare_const_a_in = s ? 8'hff : v;
                compare_const_b_in = s ? v : 8'hff;
                clear_select_in = s ? EBCT_CLR_MATCHB : EBCT_CLR_MATCHA;
                output_select_in = s ? {act, 2'h0} : {2'h0, act};
                match_irq_enable_a_in = e;
                match_irq_enable_b_in = e;
                w = waveform_output_pin_out;
                wait_until(s, prev);
                check("flag", s ? match_flag_b_out : match_flag_a_out, 8'h01);
                check("eq", prev, v);
                check("clr", count_value_out, 8'h00);
                check("irq", s ? match_irq_b_out : match_irq_a_out, e);
                check("wave", waveform_output_pin_out, wave_exp(act, w));
            end
        end
        clear_select_in = EBCT_CLR_EXT;
        load(8'h50);
        pins.clear_pulse();
        cyc(2);
        check("xclr", 8'(count_value_out < 8'h03), 8'h01);
        // gated mode: halt after clear, released by the chosen edge only
        trigger_gate_enable_in = 1'b1;
        for (int t = 1; t < 4; t++) begin
            trigger_edge_select_in = 2'(t);
            pins.clear_pulse();
            cyc(40);
            check("halt", halted_out, 1'b1);
            check("zero", count_value_out, 8'h00);
            pins.trig_set(1'b1);
            cyc(3);
            if (t == 2) begin
                check("rise", halted_out, 1'b1);
                pins.trig_set(1'b0);
                cyc(3);
            end
            check("go", halted_out, 1'b0);
            cyc(20);
            check("run", 8'(count_value_out != 8'h00), 8'h01);
            pins.trig_set(1'b0);
        end
        trigger_gate_enable_in = 1'b0;
        print_verdict();
    end
endmodule : tb_ebct_timer
